// ---- apsp_panel.sv ----
// Protection, lamp and display page controller for the linear amplifier front panel
//
// Behaviour
// R1 - Bypass and bypass lamp in receive, when disabled, or when blocked by a problem.
// R2 - Transmit lamp lit whenever the amplifier is switched into transmit.
// R3 - A fault lights the lamp steadily and holds bypass until it clears.
// R4 - Protection that reduces power or forces bypass makes the lamp flash.
// R5 - Display content is split into four pages of two rows.
// R6 - Top row always carries receive/transmit mode and frequency in 10 kHz steps.
// R7 - Each button press moves to the next page, wrapping; page stays otherwise.
// R8 - First page in transmit shows forward power then standing-wave ratio.
// R9 - Second page in transmit shows forward and reflected power.
// R10 - Status page shows the number of faults and of warnings.
// R11 - Lamp steady if faults, flashing if only warnings, off if none.
// R12 - Last page lists active messages, each tagged fault or warning.
// R13 - Frequency shown only after successful tuning, blank otherwise.
// R14 - Power values update continuously; message content refreshes on page entry.
// R15 - Protection resets on push-to-talk release and retriggers if cause persists.
// R16 - Each of four module failures is its own fault; bypass, no transmit.
// R17 - Drive overload raises a fault and holds bypass until it clears.
// R18 - Harmonic filter problem raises a latch fault; bypass, no transmit.
// R19 - Overheat raises a fault; bypass, no transmit, until temperature falls.
// R20 - High temperature raises a warning and halves power while it persists.
// R21 - Excessive reflection raises a warning and holds bypass until it clears.
// R22 - Full power to ratio 1.5, linearly down to half power at ratio 4.
// R23 - First page after reset; counts come from currently active conditions.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module apsp_panel #(
    parameter int unsigned FLASH_HALF_CYCLES = apsp_pkg::FLASH_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins from exciter, operator and sensors
    input  wire logic        ptt,
    input  wire logic        page_button,
    input  wire logic        module_one_failure,
    input  wire logic        module_two_failure,
    input  wire logic        module_three_failure,
    input  wire logic        module_four_failure,
    input  wire logic        drive_overload_sense,
    input  wire logic        filter_latch_sense,
    input  wire logic        overheat_sense,
    input  wire logic        temp_high_sense,
    input  wire logic        reflection_sense,
    // RF path and lamps
    output logic             rf_bypass,
    output logic             rf_transmit,
    output logic [6:0]       drive_pct,
    output logic             lamp_bypass,
    output logic             lamp_tx,
    output logic             lamp_fault,
    // Display contents
    output logic [1:0]       disp_page,
    output logic             disp_tx,
    output logic             disp_freq_valid,
    output logic [15:0]      disp_freq,
    output logic             disp_row2_valid,
    output logic [15:0]      disp_row2_a,
    output logic [15:0]      disp_row2_b
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Number of set flags, used for both fault and warning counts
    function automatic logic [2:0] count_set(input logic [6:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 7; i++) begin
            c = c + 3'(v[i]);
        end
        return c;
    endfunction : count_set

    // Drive level versus reflection ratio, in percent
    function automatic logic [6:0] swr_pct(input logic [15:0] swr_x100);
        logic [15:0] drop;
        drop = 16'h0000;
        if (swr_x100 <= apsp_pkg::SWR_FULL_X100) begin
            return apsp_pkg::PCT_FULL;
        end
        if (swr_x100 >= apsp_pkg::SWR_HALF_X100) begin
            return apsp_pkg::PCT_HALF;
        end
        drop = (swr_x100 - apsp_pkg::SWR_FULL_X100) / apsp_pkg::SWR_STEP_X100;
        return apsp_pkg::PCT_FULL - drop[6:0];
    endfunction : swr_pct

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    localparam int PIN_W = 11;

    logic [PIN_W-1:0] pins_s;

    apsp_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({reflection_sense, temp_high_sense, overheat_sense,
                    filter_latch_sense, drive_overload_sense,
                    module_four_failure, module_three_failure,
                    module_two_failure, module_one_failure,
                    page_button, ptt}),
        .sync_out (pins_s)
    );

    logic       ptt_s;
    logic       button_s;
    logic [6:0] fault_live;
    logic       temp_high_s;
    logic       reflection_s;

    assign ptt_s        = pins_s[0];
    assign button_s     = pins_s[1];
    assign fault_live   = pins_s[8:2];
    assign temp_high_s  = pins_s[9];
    assign reflection_s = pins_s[10];

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic                 amp_enable;
        logic [15:0]          forward;
        logic [15:0]          reflected;
        logic [15:0]          swr;
        logic [15:0]          tune_freq;
        logic                 tune_ok;
        apsp_pkg::apsp_mode_e mode;
        logic                 refl_latch;
        logic                 ptt_prev;
        logic                 btn_prev;
        logic [1:0]           page;
        logic [6:0]           snap_flt;
        logic [1:0]           snap_wrn;
        logic [31:0]          flash_cnt;
        logic                 flash_on;
        logic                 lamp_bypass;
        logic                 lamp_tx;
        logic                 lamp_fault;
        logic [6:0]           drive_pct;
        logic                 disp_tx;
        logic                 disp_freq_valid;
        logic [15:0]          disp_freq;
        logic                 disp_row2_valid;
        logic [15:0]          disp_row2_a;
        logic [15:0]          disp_row2_b;
        logic [31:0]          prdata;
        logic                 pslverr;
    } apsp_state_s;

    apsp_state_s st_r;
    apsp_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Combinational status terms
    logic [1:0] warn_live;
    logic [2:0] fault_cnt;
    logic [2:0] warn_cnt;
    logic       blocked;
    logic       ptt_release;
    logic       page_press;
    logic       setup;
    logic       access;
    logic [6:0] pct_swr;
    logic [6:0] pct_temp;

    always_comb begin
        warn_live = '0;
        warn_live[apsp_pkg::WRN_HALF_POWER] = temp_high_s;              // [R20]
        warn_live[apsp_pkg::WRN_REFLECTION] = st_r.refl_latch;          // [R21]
        fault_cnt   = count_set(fault_live);                            // [R23]
        warn_cnt    = count_set({5'h00, warn_live});                    // [R23]
        // Any fault or a reflection trip keeps the path in bypass
        blocked     = (|fault_live) | st_r.refl_latch;   // [R16] [R17] [R18] [R19]
        ptt_release = st_r.ptt_prev & ~ptt_s;
        page_press  = button_s & ~st_r.btn_prev;
        setup       = psel & ~penable;
        access      = psel & penable;
        pct_swr     = swr_pct(st_r.swr);                                // [R22]
        pct_temp    = temp_high_s ? apsp_pkg::PCT_HALF : apsp_pkg::PCT_FULL; // [R20]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt          = st_r;
        st_nxt.ptt_prev = ptt_s;
        st_nxt.btn_prev = button_s;

        // Register writes take effect in the access phase
        if (access && pwrite) begin
            unique case (paddr)
                apsp_pkg::REG_CTRL: st_nxt.amp_enable = pwdata[apsp_pkg::CTRL_ENABLE_BIT];
                apsp_pkg::REG_FORWARD:   st_nxt.forward = pwdata[15:0];
                apsp_pkg::REG_REFLECTED: st_nxt.reflected = pwdata[15:0];
                apsp_pkg::REG_SWR:  st_nxt.swr = pwdata[15:0];
                apsp_pkg::REG_TUNE: begin
                    st_nxt.tune_freq = pwdata[15:0];
                    st_nxt.tune_ok   = pwdata[apsp_pkg::TUNE_OK_BIT];   // [R13]
                end
                default: ;
            endcase
        end

        // Reflection trip clears on release; a persisting cause wins
        if (ptt_release) begin
            st_nxt.refl_latch = 1'b0;                                   // [R15]
        end
        if (reflection_s && ptt_s) begin
            st_nxt.refl_latch = 1'b1;                                   // [R15] [R21]
        end

        // Switching state
        unique case (st_r.mode)
            apsp_pkg::MODE_RX: begin
                if (ptt_s && st_r.amp_enable) begin
                    st_nxt.mode = blocked ? apsp_pkg::MODE_BLOCKED : apsp_pkg::MODE_TX;
                end
            end
            apsp_pkg::MODE_TX: begin
                if (!ptt_s || !st_r.amp_enable) begin
                    st_nxt.mode = apsp_pkg::MODE_RX;
                end else if (blocked) begin
                    st_nxt.mode = apsp_pkg::MODE_BLOCKED;               // [R3]
                end
            end
            apsp_pkg::MODE_BLOCKED: begin
                if (!ptt_s || !st_r.amp_enable) begin
                    st_nxt.mode = apsp_pkg::MODE_RX;
                end else if (!blocked) begin
                    st_nxt.mode = apsp_pkg::MODE_TX;
                end
            end
            default: st_nxt.mode = apsp_pkg::MODE_RX;
        endcase

        // Lamps and RF path; bypass is the safe default of the relay
        st_nxt.lamp_tx     = (st_nxt.mode == apsp_pkg::MODE_TX);        // [R2]
        st_nxt.lamp_bypass = ~st_nxt.lamp_tx;                           // [R1]
        st_nxt.drive_pct   = (pct_swr < pct_temp) ? pct_swr : pct_temp; // [R20] [R22]

        // Flash timer free-runs so the blink rate is steady
        if (st_r.flash_cnt >= FLASH_HALF_CYCLES - 1) begin
            st_nxt.flash_cnt = 32'h0000_0000;
            st_nxt.flash_on  = ~st_r.flash_on;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 32'h0000_0001;
        end
        if (fault_cnt != 3'h0) begin
            st_nxt.lamp_fault = 1'b1;                                   // [R3] [R11]
        end else if (warn_cnt != 3'h0) begin
            st_nxt.lamp_fault = st_nxt.flash_on;                        // [R4] [R11]
        end else begin
            st_nxt.lamp_fault = 1'b0;                                   // [R11]
        end

        // Page advance; message content is captured on entry only
        if (page_press) begin
            st_nxt.page = st_r.page + 2'h1;                             // [R7]
            if (st_nxt.page == apsp_pkg::PAGE_STATUS ||
                st_nxt.page == apsp_pkg::PAGE_MESSAGES) begin
                st_nxt.snap_flt = fault_live;                           // [R14]
                st_nxt.snap_wrn = warn_live;                            // [R14]
            end
        end

        // Top row
        st_nxt.disp_tx         = (st_r.mode != apsp_pkg::MODE_RX);      // [R6]
        st_nxt.disp_freq_valid = st_r.tune_ok;                          // [R13]
        st_nxt.disp_freq       = st_r.tune_ok ? st_r.tune_freq : 16'h0000; // [R6] [R13]

        // Second row per page; power values track live readings
        unique case (st_r.page)                                         // [R5]
            apsp_pkg::PAGE_FIRST: begin
                st_nxt.disp_row2_valid = st_nxt.disp_tx;                // [R8]
                st_nxt.disp_row2_a     = st_r.forward;                  // [R8] [R14]
                st_nxt.disp_row2_b     = st_r.swr;                      // [R8] [R14]
            end
            apsp_pkg::PAGE_SECOND: begin
                st_nxt.disp_row2_valid = st_nxt.disp_tx;                // [R9]
                st_nxt.disp_row2_a     = st_r.forward;                  // [R9] [R14]
                st_nxt.disp_row2_b     = st_r.reflected;                // [R9] [R14]
            end
            apsp_pkg::PAGE_STATUS: begin
                st_nxt.disp_row2_valid = 1'b1;
                st_nxt.disp_row2_a     = {13'h0000, count_set(st_r.snap_flt)};          // [R10]
                st_nxt.disp_row2_b     = {13'h0000, count_set({5'h00, st_r.snap_wrn})}; // [R10]
            end
            apsp_pkg::PAGE_MESSAGES: begin
                // Field a holds fault messages, field b warnings
                st_nxt.disp_row2_valid = 1'b1;
                st_nxt.disp_row2_a     = {9'h000, st_r.snap_flt};       // [R12]
                st_nxt.disp_row2_b     = {14'h0000, st_r.snap_wrn};     // [R12]
            end
        endcase

        // Read data and error prepared in setup, shown in the access phase
        if (setup) begin
            st_nxt.prdata  = 32'h0000_0000;
            st_nxt.pslverr = 1'b0;
            unique case (paddr)
                apsp_pkg::REG_CTRL: st_nxt.prdata[apsp_pkg::CTRL_ENABLE_BIT] = st_r.amp_enable;
                apsp_pkg::REG_FORWARD:   st_nxt.prdata[15:0] = st_r.forward;
                apsp_pkg::REG_REFLECTED: st_nxt.prdata[15:0] = st_r.reflected;
                apsp_pkg::REG_SWR:  st_nxt.prdata[15:0] = st_r.swr;
                apsp_pkg::REG_TUNE: begin
                    st_nxt.prdata[15:0]                  = st_r.tune_freq;
                    st_nxt.prdata[apsp_pkg::TUNE_OK_BIT] = st_r.tune_ok;
                end
                apsp_pkg::REG_STATUS: begin
                    st_nxt.prdata[apsp_pkg::ST_TX_BIT]       = st_r.lamp_tx;
                    st_nxt.prdata[apsp_pkg::ST_BYPASS_BIT]   = st_r.lamp_bypass;
                    st_nxt.prdata[apsp_pkg::ST_LAMP_BIT]     = st_r.lamp_fault;
                    st_nxt.prdata[apsp_pkg::ST_FLASHING_BIT] = (fault_cnt == 3'h0) &&
                                                               (warn_cnt != 3'h0);
                    st_nxt.prdata[apsp_pkg::ST_FCNT_LSB +: 3] = fault_cnt;
                    st_nxt.prdata[apsp_pkg::ST_WCNT_LSB +: 2] = warn_cnt[1:0];
                    st_nxt.prdata[apsp_pkg::ST_PAGE_LSB +: 2] = st_r.page;
                    st_nxt.prdata[apsp_pkg::ST_PCT_LSB +: 7]  = st_r.drive_pct;
                    st_nxt.pslverr = pwrite;     // Status is read-only
                end
                apsp_pkg::REG_COND: begin
                    st_nxt.prdata[6:0] = fault_live;
                    st_nxt.prdata[apsp_pkg::COND_WARN_LSB +: 2] = warn_live;
                    st_nxt.pslverr = pwrite;
                end
                default: st_nxt.pslverr = 1'b1;  // Unmapped address
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= '0;
            st_r.amp_enable <= apsp_pkg::RST_ENABLE;
            st_r.forward    <= apsp_pkg::RST_POWER;
            st_r.reflected  <= apsp_pkg::RST_POWER;
            st_r.swr        <= apsp_pkg::RST_SWR_X100;
            st_r.tune_freq  <= apsp_pkg::RST_FREQ;
            st_r.mode       <= apsp_pkg::MODE_RX;
            st_r.page       <= apsp_pkg::RST_PAGE;                      // [R23]
            st_r.lamp_bypass <= 1'b1;                                   // [R1]
            st_r.drive_pct  <= apsp_pkg::PCT_FULL;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; APB answers with no wait state
    assign pready          = 1'b1;
    assign prdata          = st_r.prdata;
    assign pslverr         = access & st_r.pslverr;
    assign rf_bypass       = st_r.lamp_bypass;                          // [R1]
    assign rf_transmit     = st_r.lamp_tx;
    assign drive_pct       = st_r.drive_pct;
    assign lamp_bypass     = st_r.lamp_bypass;
    assign lamp_tx         = st_r.lamp_tx;
    assign lamp_fault      = st_r.lamp_fault;
    assign disp_page       = st_r.page;
    assign disp_tx         = st_r.disp_tx;
    assign disp_freq_valid = st_r.disp_freq_valid;
    assign disp_freq       = st_r.disp_freq;
    assign disp_row2_valid = st_r.disp_row2_valid;
    assign disp_row2_a     = st_r.disp_row2_a;
    assign disp_row2_b     = st_r.disp_row2_b;

endmodule : apsp_panel

// ---- apsp_pkg.sv ----
// Package: register map, field positions, reset values and timing for the panel controller
package apsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_FORWARD    = 8'h04;
    localparam logic [7:0]  REG_REFLECTED  = 8'h08;
    localparam logic [7:0]  REG_SWR        = 8'h0C;
    localparam logic [7:0]  REG_TUNE       = 8'h10;
    localparam logic [7:0]  REG_STATUS     = 8'h14;
    localparam logic [7:0]  REG_COND       = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_ENABLE_BIT    = 0;
    localparam int TUNE_OK_BIT        = 16;
    localparam int ST_TX_BIT          = 0;
    localparam int ST_BYPASS_BIT      = 1;
    localparam int ST_LAMP_BIT        = 2;
    localparam int ST_FLASHING_BIT    = 3;
    localparam int ST_FCNT_LSB        = 4;
    localparam int ST_WCNT_LSB        = 8;
    localparam int ST_PAGE_LSB        = 11;
    localparam int ST_PCT_LSB         = 16;
    localparam int COND_WARN_LSB      = 8;

    // Fault flag positions
    localparam int FLT_MODULE_ONE     = 0;
    localparam int FLT_MODULE_FOUR    = 3;
    localparam int FLT_DRIVE_OVERLOAD = 4;
    localparam int FLT_FILTER_LATCH   = 5;
    localparam int FLT_OVERHEAT       = 6;
    localparam int FLT_COUNT          = 7;
    // Warning flag positions
    localparam int WRN_HALF_POWER     = 0;
    localparam int WRN_REFLECTION     = 1;
    localparam int WRN_COUNT          = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        RST_ENABLE     = 1'b1;
    localparam logic [15:0] RST_POWER      = 16'h0000;
    localparam logic [15:0] RST_SWR_X100   = 16'h0064;
    localparam logic [15:0] RST_FREQ       = 16'h0000;
    localparam logic [1:0]  RST_PAGE       = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Pages and power reduction curve
    localparam logic [1:0]  PAGE_FIRST     = 2'h0;
    localparam logic [1:0]  PAGE_SECOND    = 2'h1;
    localparam logic [1:0]  PAGE_STATUS    = 2'h2;
    localparam logic [1:0]  PAGE_MESSAGES  = 2'h3;
    localparam logic [15:0] SWR_FULL_X100  = 16'h0096;
    localparam logic [15:0] SWR_HALF_X100  = 16'h0190;
    localparam logic [15:0] SWR_STEP_X100  = 16'h0005;
    localparam logic [6:0]  PCT_FULL       = 7'h64;
    localparam logic [6:0]  PCT_HALF       = 7'h32;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ            = 100;
    localparam int FLASH_HALF_MS      = 250;
    localparam int FLASH_HALF_CYC     = FLASH_HALF_MS * 1000 * CLK_MHZ;

    // Amplifier switching state
    typedef enum logic [1:0] {
        MODE_RX,
        MODE_TX,
        MODE_BLOCKED
    } apsp_mode_e;

endpackage : apsp_pkg

// ---- apsp_sync.sv ----
// Two flip-flop synchroniser for a vector of independent pin levels
`timescale 1ns/10ps
module apsp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } apsp_sync_s;

    apsp_sync_s sync_r;
    apsp_sync_s sync_nxt;

    // Stage one feeds stage two only, to keep metastability contained
    always_comb begin
        sync_nxt        = sync_r;
        sync_nxt.stage1 = async_in;
        sync_nxt.stage2 = sync_r.stage1;
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r.stage2;

endmodule : apsp_sync

// ---- apsp_assertions.sv ----
// Checker: lamp, path, page and drive relations at the panel ports
`timescale 1ns/10ps
module apsp_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       pready,
    input wire logic       page_button,
    input wire logic       module_one_failure,
    input wire logic       temp_high_sense,
    input wire logic       rf_bypass,
    input wire logic       rf_transmit,
    input wire logic [6:0] drive_pct,
    input wire logic       lamp_bypass,
    input wire logic       lamp_tx,
    input wire logic       lamp_fault,
    input wire logic [1:0] disp_page
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Causes held long enough to cross the two flop synchroniser
    sequence s_fault_held; module_one_failure[*6]; endsequence
    sequence s_hot_held; temp_high_sense[*6]; endsequence
    sequence s_button_idle; (!page_button)[*5]; endsequence
    property p_bypass_lamp; lamp_bypass == rf_bypass; endproperty
    a_bypass_lamp: assert property (p_bypass_lamp) else $error("bypass lamp off path");
    property p_tx_lamp; lamp_tx == rf_transmit; endproperty
    a_tx_lamp: assert property (p_tx_lamp) else $error("tx lamp off path");
    property p_exclusive; rf_transmit |-> !rf_bypass; endproperty
    a_exclusive: assert property (p_exclusive) else $error("bypass while transmitting");
    property p_fault; s_fault_held |-> lamp_fault && rf_bypass && !rf_transmit; endproperty
    a_fault: assert property (p_fault) else $error("fault not holding bypass");
    property p_half; s_hot_held |-> drive_pct <= 7'h32; endproperty
    a_half: assert property (p_half) else $error("drive not halved when hot");
    property p_step; disp_page != $past(disp_page) |-> disp_page == $past(disp_page) + 2'h1;
    endproperty
    a_step: assert property (p_step) else $error("page skipped");
    property p_hold; s_button_idle |-> $stable(disp_page); endproperty
    a_hold: assert property (p_hold) else $error("page moved without press");
    property p_reset; $rose(presetn) |-> !disp_page && rf_bypass && pready; endproperty
    a_reset: assert property (p_reset) else $error("not on first page after reset");
endmodule : apsp_assertions
////////////////////////////////////////////////////////////////////////////////
bind apsp_panel apsp_assertions u_chk (.*);

// ---- apsp_partner.sv ----
// Exciter push-to-talk and operator page button model
`timescale 1ns/10ps
module apsp_partner (
    input  wire logic pclk,
    output logic      ptt,
    output logic      page_button
);
    initial begin
        ptt = 1'b0;
        page_button = 1'b0;
    end
    // Keying level changes only just after a clock edge
    task automatic key(input logic on);
        ptt <= on;
    endtask : key
    // Held low after release so the edge detector rearms; no bounce modelled
    task automatic press();
        page_button <= 1'b1;
        repeat (3) @(posedge pclk);
        page_button <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : press
endmodule : apsp_partner

// ---- tb_amp_protection_status_panel.sv ----
// Testbench: APB access, pin stimulus and panel output checks
`timescale 1ns/10ps
module tb_amp_protection_status_panel;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, f;
    logic        ptt, page_button, rf_bypass, rf_transmit, lamp_bypass, lamp_tx, lamp_fault;
    logic        disp_tx, disp_freq_valid, disp_row2_valid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  drive_pct;
    logic [1:0]  disp_page;
    logic [15:0] disp_freq, disp_row2_a, disp_row2_b;
    logic [8:0]  sense;
    int          n_errors, n_checks;
    // Short flash period keeps the run brief
    apsp_panel #(.FLASH_HALF_CYCLES(8)) DUT (.*, .module_one_failure(sense[0]),
        .module_two_failure(sense[1]), .module_three_failure(sense[2]),
        .module_four_failure(sense[3]), .drive_overload_sense(sense[4]),
        .filter_latch_sense(sense[5]), .overheat_sense(sense[6]),
        .temp_high_sense(sense[7]), .reflection_sense(sense[8]));
    apsp_partner u_op (.pclk(pclk), .ptt(ptt), .page_button(page_button));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sense} = '0;
        n_errors = 0;
        n_checks = 0;
        tick(10);
        presetn <= 1'b1;
        tick(1);
        apb(1'b0, apsp_pkg::REG_STATUS, 32'h0); chk(rd, 32'h0064_0002);
        apb(1'b0, 8'h1C, 32'h0); chk({err, rd}, 33'h1_0000_0000);
        apb(1'b1, apsp_pkg::REG_STATUS, 32'hFFFF_FFFF); chk(err, 1'b1);
        apb(1'b1, apsp_pkg::REG_TUNE, 32'h0001_04D2); tick(2);
        chk({disp_freq_valid, disp_freq}, 17'h104D2);
        apb(1'b1, apsp_pkg::REG_TUNE, 32'h0000_04D2); tick(2);
        chk({disp_freq_valid, disp_freq}, 17'h0);
        // Ratio 2.00 lies on the slope: 100 - 50/5 percent
        apb(1'b1, apsp_pkg::REG_FORWARD, 32'h0000_03E8);
        apb(1'b1, apsp_pkg::REG_REFLECTED, 32'h0000_0010);
        apb(1'b1, apsp_pkg::REG_SWR, 32'h0000_00C8);
        u_op.key(1'b1); tick(8);
        chk({lamp_tx, lamp_bypass, disp_tx, drive_pct}, {3'h5, 7'h5A});
        chk({disp_row2_valid, disp_row2_a, disp_row2_b}, 33'h1_03E8_00C8);
        u_op.press(); tick(4);
        chk({disp_page, disp_row2_b}, 18'h1_0010);
        // Warm only: half drive and a flashing lamp while still transmitting
        sense <= 9'h080; tick(6);
        chk({lamp_tx, drive_pct}, 8'hB2);
        f = lamp_fault; tick(8);
        chk(f ^ lamp_fault, 1'b1);
        sense <= 9'h100; tick(6);
        chk({lamp_tx, lamp_bypass}, 2'h1);
        sense <= 9'h000; tick(6);
        chk(lamp_bypass, 1'b1);
        u_op.key(1'b0); tick(4); u_op.key(1'b1); tick(8);
        chk({lamp_tx, lamp_fault}, 2'h2);
        for (int i = 0; i < 7; i++) begin
            sense <= 9'(1 << i); tick(6);
            chk({rf_bypass, lamp_tx, lamp_fault}, 3'h5);
            apb(1'b0, apsp_pkg::REG_COND, 32'h0); chk(rd, 32'(1 << i));
        end
        sense <= 9'h0C0; tick(6);
        u_op.press(); tick(4);
        chk({disp_page, disp_row2_a, disp_row2_b}, 34'h2_0001_0001);
        u_op.press(); tick(4);
        chk({disp_page, disp_row2_a, disp_row2_b}, 34'h3_0040_0001);
        sense <= 9'h000; tick(8);
        chk(disp_row2_a, 16'h0040);
        u_op.press(); tick(4);
        chk(disp_page, 2'h0);
        u_op.key(1'b0); tick(4);
        print_verdict();
    end
    // Watchdog well beyond the roughly two hundred cycles the sequence needs
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule : tb_amp_protection_status_panel
